// *** hdl/afe_pkg.sv ***
// constants for the acquisition front-end control block
// assumes a byte-wide data-memory port from the on-chip processor
package afe_pkg;
  // data-memory map
  localparam logic [7:0] AFE_CFG_ADDR = 8'h10;
  localparam logic [7:0] AFE_CONV_ADDR = 8'h11;
  // front-end config field positions
  localparam int AFE_THERMISTOR_BIAS_SWITCH_BIT = 7;
  localparam int AFE_BIASCAN_BIT = 6;
  localparam int AFE_REGSRC_BIT = 5;
  localparam int AFE_RSVD_BIT = 4;
  localparam int AFE_CHAN_LSB = 0;
  localparam int AFE_CHAN_W = 4;
  localparam logic [7:0] AFE_CFG_RESET = 8'h00;
  // conversion control field positions
  localparam int AFE_START_BIT = 7;
  localparam int AFE_PEND_BIT = 6;
  localparam int AFE_RES_LSB = 1;
  localparam int AFE_RES_W = 3;
  localparam int AFE_IEN_BIT = 0;
  localparam logic [7:0] AFE_CONV_RESET = 8'h00;
  // resolution in bits is this base plus the field
  localparam logic [4:0] AFE_RES_BASE = 5'h09;
  // channel codes
  localparam logic [3:0] AFE_CH_GROUND = 4'h0;
  localparam logic [3:0] AFE_CH_DIE_TEMP = 4'h1;
  localparam logic [3:0] AFE_CH_SENSE = 4'h4;
  localparam logic [3:0] AFE_CH_TAP1_NEG = 4'h8;
  localparam logic [3:0] AFE_CH_TAP1_DIFF = 4'hC;
  // measurement ranges
  typedef enum logic [1:0] {
    AFE_RANGE_LOW = 2'h0,
    AFE_RANGE_HIGH = 2'h1,
    AFE_RANGE_MICRO = 2'h2,
    AFE_RANGE_TEMP = 2'h3
  } afe_range_t;
  // sequencer states, gray along the path
  typedef enum logic [1:0] {
    AFE_ST_IDLE = 2'h0,
    AFE_ST_SETTLE = 2'h1,
    AFE_ST_CONVERT = 2'h3,
    AFE_ST_FINISH = 2'h2
  } afe_state_t;
  // converter power-up settling
  localparam int AFE_CLK_PERIOD_NS = 100;
  localparam int AFE_SETTLE_NS = 500;
  localparam int AFE_SETTLE_CYC = (AFE_SETTLE_NS + AFE_CLK_PERIOD_NS - 1) / AFE_CLK_PERIOD_NS;
endpackage

// *** hdl/afe_conv_if.sv ***
// carrier between the register side and the conversion sequencer
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface afe_conv_if;
  logic start_req;
  logic conv_done;
  logic powered;
  logic running;
  logic finish;
  modport seq (input start_req, input conv_done,
               output powered, output running, output finish);
  modport ctl (output start_req, output conv_done,
               input powered, input running, input finish);
endinterface
`default_nettype wire

// *** hdl/afe_conv_seq.sv ***
// conversion sequencer: powers the converter, runs it, powers it down
// assumes conv_done is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none
module afe_conv_seq
  import afe_pkg::*;
#(
  parameter int SETTLE_CYC = AFE_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  afe_conv_if.seq cv
);
  afe_state_t state_r;
  logic [7:0] settle_r;

  // ==========================================================
  // state machine
  // R4 runs on its own
  // no processor signal can stall the sequence once started
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= AFE_ST_IDLE;
    end else begin
      case (state_r)
        AFE_ST_IDLE: if (cv.start_req) state_r <= AFE_ST_SETTLE;
        AFE_ST_SETTLE: if (settle_r == 8'h00) state_r <= AFE_ST_CONVERT;
        AFE_ST_CONVERT: if (cv.conv_done) state_r <= AFE_ST_FINISH;
        AFE_ST_FINISH: state_r <= AFE_ST_IDLE;
        default: state_r <= AFE_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_r <= 8'h00;
    end else if (state_r == AFE_ST_IDLE) begin
      settle_r <= 8'(SETTLE_CYC - 1);
    end else if (settle_r != 8'h00) begin
      settle_r <= settle_r - 8'h01;
    end
  end

  // ==========================================================
  // outputs
  // R3 auto power down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cv.powered <= 1'b0;
      cv.running <= 1'b0;
      cv.finish <= 1'b0;
    end else begin
      cv.powered <= (state_r == AFE_ST_IDLE) ? cv.start_req :
                    (state_r == AFE_ST_CONVERT) ? !cv.conv_done :
                    (state_r == AFE_ST_SETTLE);
      cv.running <= (state_r == AFE_ST_SETTLE && settle_r == 8'h00) ||
                    (state_r == AFE_ST_CONVERT && !cv.conv_done);
      cv.finish <= (state_r == AFE_ST_CONVERT) && cv.conv_done;
    end
  end
endmodule
`default_nettype wire

// *** hdl/afe_ctrl.sv ***
// acquisition front-end control: config registers, channel routing,
// bias cancel, thermistor switch, regulator select, conversion control
// assumes a byte data-memory port on clk and an analog converter whose
// done level arrives asynchronously
//
// Summary of operation
// R1 - control and status sit in data memory; front-end config at 0x10
// R2 - eight resolutions, nine to sixteen bits
// R3 - converter powers down by itself after every conversion
// R4 - a conversion completes regardless of processor activity
// R5 - end of conversion raises an interrupt that software can mask
// R6 - bit 7 closes the thermistor switch to analog supply, else open
// R7 - bit 6 enables bias cancel on intermediate taps during conversion only
// R8 - bit 5 picks regulator source: pack positive or battery pin
// R9 - channel field resets to ground; low range codes pick six inputs
// R10 - code 0100 routes the sense differential through micro range
// R11 - code 0001 routes die temperature through temperature range
// R12 - codes 1000 to 1111 pick cell taps in the high range
// R13 - reserved bit 4 stores and reads back, no hardware effect
// R14 - software sets start bit; hardware clears it once finished
// R15 - resolution equals nine plus the three-bit field
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl
  import afe_pkg::*;
#(
  parameter int SETTLE_CYC = AFE_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  input wire logic conv_done_pin,
  output logic converter_power,
  output logic conversion_run,
  output logic [4:0] resolution_bits,
  output logic [3:0] channel_select,
  output logic [1:0] measure_range,
  output logic thermistor_bias_switch,
  output logic bias_cancel_circuit,
  output logic regulator_source_select,
  output logic conversion_irq
);
  logic [7:0] cfg_r;
  logic start_r;
  logic pend_r;
  logic ien_r;
  logic [2:0] res_r;
  logic done_meta_r;
  logic done_sync_r;
  logic wr_cfg;
  logic wr_conv;
  logic [3:0] chan;
  afe_range_t range_nxt;
  logic intermediate;

  afe_conv_if cv ();

  // ==========================================================
  // register decode
  // R1 memory mapped
  assign wr_cfg = mem_wr && (mem_addr == AFE_CFG_ADDR);
  assign wr_conv = mem_wr && (mem_addr == AFE_CONV_ADDR);
  assign chan = cfg_r[AFE_CHAN_LSB +: AFE_CHAN_W];

  // R6 R7 R8 R9 R13 config storage
  // reserved bit kept only for read-back
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= AFE_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_r <= mem_wdata;
    end
  end

  // R15 resolution field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_r <= AFE_CONV_RESET[AFE_RES_LSB +: AFE_RES_W];
      ien_r <= AFE_CONV_RESET[AFE_IEN_BIT];
    end else if (wr_conv) begin
      res_r <= mem_wdata[AFE_RES_LSB +: AFE_RES_W];
      ien_r <= mem_wdata[AFE_IEN_BIT];
    end
  end

  // R14 start set and clear
  // writing 0 cannot abort a conversion already under way
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_r <= AFE_CONV_RESET[AFE_START_BIT];
    end else if (wr_conv && mem_wdata[AFE_START_BIT]) begin
      start_r <= 1'b1;
    end else if (cv.finish) begin
      start_r <= 1'b0;
    end
  end

  // R5 sticky end flag
  // set wins over a write of 0 in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_r <= AFE_CONV_RESET[AFE_PEND_BIT];
    end else if (cv.finish) begin
      pend_r <= 1'b1;
    end else if (wr_conv && !mem_wdata[AFE_PEND_BIT]) begin
      pend_r <= 1'b0;
    end
  end

  // ==========================================================
  // read port, one cycle latency, unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd) begin
      if (mem_addr == AFE_CFG_ADDR) begin
        mem_rdata <= cfg_r;
      end else if (mem_addr == AFE_CONV_ADDR) begin
        mem_rdata <= {start_r, pend_r, 2'h0, res_r, ien_r};
      end else begin
        mem_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================
  // converter done synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_meta_r <= 1'b0;
      done_sync_r <= 1'b0;
    end else begin
      done_meta_r <= conv_done_pin;
      done_sync_r <= done_meta_r;
    end
  end

  assign cv.start_req = start_r;
  assign cv.conv_done = done_sync_r;

  afe_conv_seq #(
    .SETTLE_CYC(SETTLE_CYC)
  ) u_seq (
    .clk(clk),
    .rst(rst),
    .cv(cv.seq)
  );

  // ==========================================================
  // channel and range decode
  // R9 R10 R11 R12 range per code
  always_comb begin
    if (chan[3]) begin
      range_nxt = AFE_RANGE_HIGH;
    end else if (chan == AFE_CH_SENSE) begin
      range_nxt = AFE_RANGE_MICRO;
    end else if (chan == AFE_CH_DIE_TEMP) begin
      range_nxt = AFE_RANGE_TEMP;
    end else begin
      range_nxt = AFE_RANGE_LOW;
    end
  end

  // taps above the bottom cell are the intermediate ones
  assign intermediate = chan[3] && (chan != AFE_CH_TAP1_NEG) && (chan != AFE_CH_TAP1_DIFF);

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      channel_select <= AFE_CH_GROUND;
      measure_range <= AFE_RANGE_LOW;
    end else begin
      channel_select <= chan;
      measure_range <= range_nxt;
    end
  end

  // R6 R8 pin controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      thermistor_bias_switch <= 1'b0;
      regulator_source_select <= 1'b0;
    end else begin
      thermistor_bias_switch <= cfg_r[AFE_THERMISTOR_BIAS_SWITCH_BIT];
      regulator_source_select <= cfg_r[AFE_REGSRC_BIT];
    end
  end

  // R7 bias cancel gating
  // only while running, so the extra supply current stops between conversions
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bias_cancel_circuit <= 1'b0;
    end else begin
      bias_cancel_circuit <= cfg_r[AFE_BIASCAN_BIT] && cv.running && intermediate;
    end
  end

  // R2 R15 resolution out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resolution_bits <= AFE_RES_BASE;
    end else begin
      resolution_bits <= AFE_RES_BASE + {2'h0, res_r};
    end
  end

  // R3 R4 R5 converter and interrupt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_power <= 1'b0;
      conversion_run <= 1'b0;
      conversion_irq <= 1'b0;
    end else begin
      converter_power <= cv.powered;
      conversion_run <= cv.running;
      conversion_irq <= pend_r && ien_r;
    end
  end

  // ==========================================================
  // checks
  // R6 thermistor follows
  thermistor_bias_switch_follow_a: assert property (@(posedge clk) disable iff (rst) // R6
    wr_cfg |-> ##2 thermistor_bias_switch == $past(mem_wdata[AFE_THERMISTOR_BIAS_SWITCH_BIT], 2))
    else $error("thermistor switch does not follow bit 7");

  // R8 regulator follows
  regsrc_follow_a: assert property (@(posedge clk) disable iff (rst) // R8
    wr_cfg |-> ##2 regulator_source_select == $past(mem_wdata[AFE_REGSRC_BIT], 2))
    else $error("regulator select does not follow bit 5");

  // R7 bias cancel only while running
  bias_only_run_a: assert property (@(posedge clk) disable iff (rst) // R7
    bias_cancel_circuit |-> $past(cv.running) && $past(cfg_r[AFE_BIASCAN_BIT]))
    else $error("bias cancel active outside an enabled conversion");

  // R12 R10 R11 range decode
  range_decode_a: assert property (@(posedge clk) disable iff (rst) // R12
    ##1 (measure_range == AFE_RANGE_HIGH) == $past(chan[3]) &&
    ((measure_range == AFE_RANGE_MICRO) == ($past(chan) == AFE_CH_SENSE)) &&
    ((measure_range == AFE_RANGE_TEMP) == ($past(chan) == AFE_CH_DIE_TEMP)))
    else $error("measurement range does not match channel code");

  // R14 start clears after finish
  start_clear_a: assert property (@(posedge clk) disable iff (rst) // R14
    cv.finish && !wr_conv |=> !start_r)
    else $error("start bit not cleared at end of conversion");

  // R3 power drops at finish
  power_down_a: assert property (@(posedge clk) disable iff (rst) // R3
    cv.finish |=> !converter_power ##1 !converter_power)
    else $error("converter still powered after conversion");

  // R5 masked irq stays low
  irq_mask_a: assert property (@(posedge clk) disable iff (rst) // R5
    !ien_r |=> !conversion_irq)
    else $error("interrupt raised while masked");

  // R5 irq after finish
  irq_raise_a: assert property (@(posedge clk) disable iff (rst) // R5
    cv.finish && ien_r && !wr_conv |-> ##2 conversion_irq)
    else $error("no interrupt after end of conversion");

  // R15 resolution sum
  res_sum_a: assert property (@(posedge clk) disable iff (rst) // R15
    wr_conv |-> ##2 resolution_bits == AFE_RES_BASE + {2'h0, $past(mem_wdata[3:1], 2)})
    else $error("resolution is not nine plus field");

  // R13 reserved read-back
  rsvd_back_a: assert property (@(posedge clk) disable iff (rst) // R13
    wr_cfg ##1 (mem_rd && mem_addr == AFE_CFG_ADDR && !wr_cfg) |=>
    mem_rdata[AFE_RSVD_BIT] == $past(mem_wdata[AFE_RSVD_BIT], 2))
    else $error("reserved bit does not read back");

  // R9 channel copy
  chan_follow_a: assert property (@(posedge clk) disable iff (rst) // R9
    ##1 channel_select == $past(chan))
    else $error("channel select does not follow config");

  // R14 start set by write
  start_set_a: assert property (@(posedge clk) disable iff (rst) // R14
    wr_conv && mem_wdata[AFE_START_BIT] |=> start_r)
    else $error("start bit not set by write");

  // R5 end sets pending
  pend_set_a: assert property (@(posedge clk) disable iff (rst) // R5
    cv.finish |=> pend_r)
    else $error("pending flag not set at end of conversion");

  // R3 run only when powered
  power_run_a: assert property (@(posedge clk) disable iff (rst) // R3
    conversion_run |-> converter_power)
    else $error("converter running without power");

  conv_done_c: cover property (@(posedge clk) disable iff (rst) cv.finish);
  masked_end_c: cover property (@(posedge clk) disable iff (rst) cv.finish && !ien_r);
  micro_range_c: cover property (@(posedge clk) disable iff (rst)
    measure_range == AFE_RANGE_MICRO);
  bias_on_c: cover property (@(posedge clk) disable iff (rst) bias_cancel_circuit);
  irq_c: cover property (@(posedge clk) disable iff (rst) conversion_irq);
endmodule
`default_nettype wire

// *** dv/afe_ctrl_tb.sv ***
// self-checking bench for the acquisition front-end control block
// assumes afe_pkg and afe_ctrl compiled first; bench drives all ports itself
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl_tb;
  import afe_pkg::*;
  logic clk = 1'b0, rst = 1'b1, mem_wr = 1'b0, mem_rd = 1'b0, conv_done_pin = 1'b0;
  logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, mem_rdata;
  logic converter_power, conversion_run, thermistor_bias_switch, bias_cancel_circuit;
  logic regulator_source_select, conversion_irq, probe = 1'b0;
  logic [4:0] resolution_bits;
  logic [3:0] channel_select;
  logic [1:0] measure_range;
  logic [7:0] rd_q[$];
  logic [16:0] out_q[$];
  logic [7:0] cfg = 8'h00;
  logic [31:0] seed = 32'h19;
  int miscompares = 0, check_count = 0, cycles = 0;
  always #50 clk = ~clk;
  afe_ctrl #(.SETTLE_CYC(1)) dut (.clk(clk), .rst(rst), .mem_addr(mem_addr),
    .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .conv_done_pin(conv_done_pin), .converter_power(converter_power),
    .conversion_run(conversion_run), .resolution_bits(resolution_bits),
    .channel_select(channel_select), .measure_range(measure_range),
    .thermistor_bias_switch(thermistor_bias_switch), .bias_cancel_circuit(bias_cancel_circuit),
    .regulator_source_select(regulator_source_select), .conversion_irq(conversion_irq));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected output vector from config, resolution field and converter state
  function automatic logic [16:0] exp_out(input logic [7:0] c, input logic [2:0] f,
      input logic pw, input logic run, input logic irq);
    logic [1:0] rg;
    rg = c[3] ? 2'h1 : (c[3:0] == 4'h4) ? 2'h2 : (c[3:0] == 4'h1) ? 2'h3 : 2'h0;
    return {c[7], c[6] & run & c[3] & (c[1:0] != 2'h0), c[5], c[3:0], rg,
      5'h09 + {2'h0, f}, pw, run, irq};
  endfunction
  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value mem_rdata expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_out(input logic [16:0] e, input logic [16:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value outputs expected %h seen %h", e, s);
    end
  endtask
  // ==========================================================
  // driver tasks, change inputs on the falling edge
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    mem_addr = a;
    mem_wdata = d;
    mem_wr = wr;
    mem_rd = ~wr;
    if (!wr) rd_q.push_back(d);
    @(negedge clk);
    mem_wr = 1'b0;
    mem_rd = 1'b0;
  endtask
  task automatic chk_out(input logic [16:0] e);
    @(negedge clk);
    probe = 1'b1;
    out_q.push_back(e);
    @(negedge clk);
    probe = 1'b0;
  endtask
  task automatic conv(input logic [2:0] f, input logic ien, input logic [7:0] c);
    int i;
    acc(1'b1, 8'h10, c);
    acc(1'b1, 8'h11, {4'h8, f, ien});
    for (i = 0; i < 50 && conversion_run !== 1'b1; i++) @(negedge clk);
    chk_out(exp_out(c, f, 1'b1, 1'b1, 1'b0));
    acc(1'b0, 8'h11, {4'h8, f, ien});
    conv_done_pin = 1'b1;
    for (i = 0; i < 50 && converter_power !== 1'b0; i++) @(negedge clk);
    repeat (2) @(negedge clk);
    chk_out(exp_out(c, f, 1'b0, 1'b0, ien));
    acc(1'b0, 8'h11, {4'h4, f, ien});
    conv_done_pin = 1'b0;
    acc(1'b1, 8'h11, {4'h4, f, ien});
    acc(1'b0, 8'h11, {4'h4, f, ien});
    acc(1'b1, 8'h11, {4'h0, f, ien});
    acc(1'b0, 8'h11, {4'h0, f, ien});
    chk_out(exp_out(c, f, 1'b0, 1'b0, 1'b0));
  endtask
  // ==========================================================
  // monitor: compares oldest note once a result appears
  always @(posedge clk) begin
    logic rd_s, pr_s;
    rd_s = mem_rd;
    pr_s = probe;
    #1;
    if (rd_s) cmp_rd(rd_q.pop_front(), mem_rdata);
    if (pr_s) cmp_out(out_q.pop_front(), {thermistor_bias_switch, bias_cancel_circuit,
      regulator_source_select, channel_select, measure_range, resolution_bits,
      converter_power, conversion_run, conversion_irq});
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    acc(1'b0, 8'h10, 8'h00);
    acc(1'b0, 8'h11, 8'h00);
    chk_out(exp_out(8'h00, 3'h0, 1'b0, 1'b0, 1'b0));
    $display("test reset done");
    // every channel code with random upper bits
    for (int k = 0; k < 16; k++) begin
      seed = xs(seed);
      cfg = {seed[7:4], k[3:0]};
      acc(1'b1, 8'h10, cfg);
      acc(1'b0, 8'h10, cfg);
      chk_out(exp_out(cfg, 3'h0, 1'b0, 1'b0, 1'b0));
    end
    $display("test channels done");
    // unmapped place: write ignored, read gives zero
    acc(1'b1, 8'h12, 8'hFF);
    acc(1'b0, 8'h12, 8'h00);
    acc(1'b0, 8'h10, cfg);
    $display("test unmapped done");
    // every resolution, irq enabled and masked, bias cancel on and off taps
    for (int f = 0; f < 8; f++) begin
      seed = xs(seed);
      conv(f[2:0], f[0], {seed[7], 1'b1, seed[5:4], 2'h2, f[1], seed[0]});
    end
    $display("test conversions done");
    give_verdict();
  end
endmodule
`default_nettype wire
